// ---- hdl/point_table_defs.vh ----
// Constants shared by the point table sequencer and its helpers.
`ifndef POINT_TABLE_DEFS_VH
`define POINT_TABLE_DEFS_VH
// Register offsets.
`define REG_CTRL 4'h0
`define REG_INDEX 4'h1
`define REG_POS 4'h2
`define REG_FIELDS 4'h3
`define REG_CMD 4'h4
`define REG_STATUS 4'h5
`define REG_ACC0 4'h6
`define REG_ACC1 4'h7
`define REG_DEC0 4'h8
`define REG_DEC1 4'h9
`define REG_SELTIME 4'ha
`define REG_RUN 4'hb
`define REG_PRESENT 4'hc
// Field limits.
`define POS_MAX 32'sd39999999
`define POS_MIN (-32'sd39999999)
`define SPEED_MAX 8'd199
`define RAMP_MAX 14'd9999
`define MODE_MAX 2'd2
`define CTRL_MODE_PTP_A 8'd11
`define CTRL_MODE_PTP_B 8'd12
// Selection-time step in microseconds (0.8 ms).
`define SEL_STEP_US 16'd800
`define SEL_MAX_US 20'd800000
// Command codes.
`define CMD_CONFIRM 2'd1
`define CMD_INSERT 2'd2
`define CMD_DELETE 2'd3
// Operation modes.
`define OPM_INDEP 2'd0
`define OPM_AUTOINC 2'd1
`define OPM_CONT 2'd2
`endif

// ---- hdl/sel_time_round.v ----
// Rounds a selection-signal time in microseconds down to a multiple of the step.
`timescale 1ns/1ps
`default_nettype none
`include "point_table_defs.vh"
module sel_time_round (
   // Value in microseconds.
   input wire [19:0] time_us,
   // Rounded value.
   output wire [19:0] time_rounded
);
   wire [19:0] steps;
   wire [35:0] prod;
   assign steps = time_us / {4'h0, `SEL_STEP_US};
   assign prod = steps * {4'h0, `SEL_STEP_US};
   assign time_rounded = prod[19:0];
endmodule
`default_nettype wire

// ---- hdl/point_range_check.v ----
// Checks a candidate point entry against each field's permitted range.
`timescale 1ns/1ps
`default_nettype none
`include "point_table_defs.vh"
module point_range_check (
   // Candidate entry.
   input wire [31:0] pos,
   input wire [7:0] speed,
   input wire [1:0] ramp,
   input wire [1:0] mode,
   // Verdict.
   output wire ok
);
   wire pos_ok;
   assign pos_ok = ($signed(pos) <= `POS_MAX) && ($signed(pos) >= `POS_MIN);
   assign ok = pos_ok && (speed <= `SPEED_MAX) && (mode <= `MODE_MAX)
      && (ramp <= 2'h3);
endmodule
`default_nettype wire

// ---- hdl/point_table_sequencer.v ----
// Point-to-point positioning table with editing and sequencing.
// Contract
// - Each point holds signed position within plus or minus 39,999,999 pulses.
// - Each point stores an absolute or incremental flag.
// - Speed override per point accepts 0 to 199 percent.
// - Ramp select: tens digit picks deceleration, units digit picks acceleration.
// - Operation mode code is 0, 1 or 2 only.
// - Independent mode holds, then moves on new point number plus start.
// - Automatic incremental mode stops, next start advances to following point.
// - Continuous mode runs point to point until cancelled.
// - Table writes allowed only in control mode 11 or 12.
// - Edits commit only on an explicit confirm command.
// - Insert writes entry at index and moves later entries up.
// - Insert refused unless the last point holds data.
// - Delete moves later entries down by one index.
// - After delete the last entry is cleared to zero.
// - Selection time stored rounded down to multiple of 0.8 ms.
// - Each of four ramp times holds 0 to 9,999 ms.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "point_table_defs.vh"
module point_table_sequencer #(
   parameter DEPTH = 64,
   parameter IW = 6
) (
   // Clock and reset.
   input wire core_clk,
   input wire sys_rst,
   // Register port.
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // Motion controller handshake.
   input wire move_done,
   output reg move_start,
   output reg [31:0] target_pos,
   output reg target_incr,
   output reg [7:0] target_speed,
   output reg [13:0] target_accel,
   output reg [13:0] target_decel,
   output reg servo_lock,
   output reg [IW-1:0] present_point
);
   // Entry layout: pos[31:0], incr[32], speed[40:33], ramp[42:41], mode[44:43].
   localparam EW = 45;
   localparam S_IDLE = 2'd0;
   localparam S_MOVE = 2'd1;
   localparam S_LOCK = 2'd2;
   reg [EW-1:0] table_mem [0:DEPTH-1];
   wire [EW-1:0] last_point_entry;
   reg [7:0] ctrl_mode_r;
   reg [IW-1:0] index_r;
   reg [31:0] edit_pos_r;
   reg edit_incr_r;
   reg [7:0] edit_speed_r;
   reg [1:0] edit_ramp_r;
   reg [1:0] edit_mode_r;
   reg [13:0] accel_time_zero_r;
   reg [13:0] accel_time_one_r;
   reg [13:0] decel_time_zero_r;
   reg [13:0] decel_time_one_r;
   reg [19:0] select_signal_on_time_r;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [IW-1:0] run_point_r;
   reg new_point_r;
   reg cont_enable_r;
   reg refused_r;
   reg last_filled_r;
   wire [EW-1:0] edit_entry;
   wire edit_ok;
   wire [19:0] sel_rounded;
   wire write_allowed;
   wire [EW-1:0] cur_entry;
   wire [1:0] cur_mode;
   wire [IW-1:0] next_point;
   wire start_req;
   wire confirm_command;
   wire insert_command;
   wire delete_command;
   wire last_filled;
   integer i;

   assign edit_entry = {edit_mode_r, edit_ramp_r, edit_speed_r, edit_incr_r, edit_pos_r};
   assign write_allowed = (ctrl_mode_r == `CTRL_MODE_PTP_A)
      || (ctrl_mode_r == `CTRL_MODE_PTP_B);
   assign confirm_command = reg_wr && (reg_addr == `REG_CMD) && (reg_wdata[1:0] == `CMD_CONFIRM);
   assign insert_command = reg_wr && (reg_addr == `REG_CMD) && (reg_wdata[1:0] == `CMD_INSERT);
   assign delete_command = reg_wr && (reg_addr == `REG_CMD) && (reg_wdata[1:0] == `CMD_DELETE);
   assign last_filled = last_point_entry != {EW{1'b0}};
   assign cur_entry = table_mem[run_point_r];
   assign cur_mode = cur_entry[44:43];
   assign next_point = run_point_r + {{(IW-1){1'b0}}, 1'b1};
   assign start_req = reg_wr && (reg_addr == `REG_RUN) && reg_wdata[0];

   point_range_check range_chk (
      .pos(edit_pos_r),
      .speed(edit_speed_r),
      .ramp(edit_ramp_r),
      .mode(edit_mode_r),
      .ok(edit_ok)
   );

   sel_time_round sel_round (
      .time_us(reg_wdata[19:0]),
      .time_rounded(sel_rounded)
   );

   assign last_point_entry = table_mem[DEPTH-1];

   // Table storage and edit commands.
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            table_mem[i] <= {EW{1'b0}};
         end
         refused_r <= 1'b0;
      end else if (write_allowed) begin
         if (confirm_command) begin
            if (edit_ok) begin
               table_mem[index_r] <= edit_entry;
               refused_r <= 1'b0;
            end else begin
               refused_r <= 1'b1;
            end
         end else if (insert_command) begin
            if (last_filled && edit_ok) begin
               for (i = 1; i < DEPTH; i = i + 1) begin
                  if (i > index_r) begin
                     table_mem[i] <= table_mem[i-1];
                  end
               end
               table_mem[index_r] <= edit_entry;
               refused_r <= 1'b0;
            end else begin
               refused_r <= 1'b1;
            end
         end else if (delete_command) begin
            for (i = 0; i < DEPTH-1; i = i + 1) begin
               if (i >= index_r) begin
                  table_mem[i] <= table_mem[i+1];
               end
            end
            table_mem[DEPTH-1] <= {EW{1'b0}};
            refused_r <= 1'b0;
         end
      end else if (confirm_command || insert_command || delete_command) begin
         refused_r <= 1'b1;
      end
   end

   // Configuration and edit buffer registers.
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_mode_r <= 8'h00;
         index_r <= {IW{1'b0}};
         edit_pos_r <= 32'h0000_0000;
         edit_incr_r <= 1'b0;
         edit_speed_r <= 8'h00;
         edit_ramp_r <= 2'h0;
         edit_mode_r <= 2'h0;
         accel_time_zero_r <= 14'h0000;
         accel_time_one_r <= 14'h0000;
         decel_time_zero_r <= 14'h0000;
         decel_time_one_r <= 14'h0000;
         select_signal_on_time_r <= 20'h00000;
         new_point_r <= 1'b0;
         cont_enable_r <= 1'b0;
      end else begin
         if (reg_wr) begin
            case (reg_addr)
               `REG_CTRL: begin
                  ctrl_mode_r <= reg_wdata[7:0];
               end
               `REG_INDEX: begin
                  index_r <= reg_wdata[IW-1:0];
                  new_point_r <= 1'b1;
               end
               `REG_POS: begin
                  edit_pos_r <= reg_wdata;
               end
               `REG_FIELDS: begin
                  edit_incr_r <= reg_wdata[0];
                  edit_speed_r <= reg_wdata[15:8];
                  edit_ramp_r <= {reg_wdata[20], reg_wdata[16]};
                  edit_mode_r <= reg_wdata[25:24];
               end
               `REG_ACC0: begin
                  if (reg_wdata[13:0] <= `RAMP_MAX) accel_time_zero_r <= reg_wdata[13:0];
               end
               `REG_ACC1: begin
                  if (reg_wdata[13:0] <= `RAMP_MAX) accel_time_one_r <= reg_wdata[13:0];
               end
               `REG_DEC0: begin
                  if (reg_wdata[13:0] <= `RAMP_MAX) decel_time_zero_r <= reg_wdata[13:0];
               end
               `REG_DEC1: begin
                  if (reg_wdata[13:0] <= `RAMP_MAX) decel_time_one_r <= reg_wdata[13:0];
               end
               `REG_SELTIME: begin
                  if (reg_wdata[19:0] <= `SEL_MAX_US) begin
                     select_signal_on_time_r <= sel_rounded;
                  end
               end
               `REG_RUN: begin
                  cont_enable_r <= reg_wdata[1];
               end
               default: begin
               end
            endcase
         end
         if (start_req && state_r != S_MOVE && !(reg_addr == `REG_INDEX)) begin
            new_point_r <= 1'b0;
         end
      end
   end

   // Sequencer state machine.
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE, S_LOCK: begin
            if (start_req) state_nxt = S_MOVE;
         end
         S_MOVE: begin
            if (move_done) begin
               if (cur_mode == `OPM_CONT && cont_enable_r) state_nxt = S_MOVE;
               else state_nxt = S_LOCK;
            end
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= S_IDLE;
         run_point_r <= {IW{1'b0}};
         move_start <= 1'b0;
         servo_lock <= 1'b0;
         present_point <= {IW{1'b0}};
         target_pos <= 32'h0000_0000;
         target_incr <= 1'b0;
         target_speed <= 8'h00;
         target_accel <= 14'h0000;
         target_decel <= 14'h0000;
      end else begin
         state_r <= state_nxt;
         move_start <= 1'b0;
         if (state_r != S_MOVE && start_req) begin
            if (new_point_r || state_r == S_IDLE) begin
               run_point_r <= index_r;
            end else if (cur_mode == `OPM_AUTOINC) begin
               run_point_r <= next_point;
            end
            move_start <= 1'b1;
            servo_lock <= 1'b0;
         end else if (state_r == S_MOVE && move_done) begin
            if (cur_mode == `OPM_CONT && cont_enable_r) begin
               run_point_r <= next_point;
               move_start <= 1'b1;
            end else begin
               servo_lock <= 1'b1;
            end
         end
         if (move_start) begin
            present_point <= run_point_r;
            target_pos <= cur_entry[31:0];
            target_incr <= cur_entry[32];
            target_speed <= cur_entry[40:33];
            target_accel <= cur_entry[41] ? accel_time_one_r : accel_time_zero_r;
            target_decel <= cur_entry[42] ? decel_time_one_r : decel_time_zero_r;
         end
      end
   end

   // Read port.
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `REG_CTRL: reg_rdata <= {24'h000000, ctrl_mode_r};
            `REG_INDEX: reg_rdata <= {{(32-IW){1'b0}}, index_r};
            `REG_POS: reg_rdata <= table_mem[index_r][31:0];
            `REG_FIELDS: reg_rdata <= {6'h00, table_mem[index_r][44:43], 3'h0,
               table_mem[index_r][42], 3'h0, table_mem[index_r][41],
               table_mem[index_r][40:33], 7'h00, table_mem[index_r][32]};
            `REG_STATUS: reg_rdata <= {27'h0000000, last_filled, refused_r, write_allowed,
               state_r};
            `REG_ACC0: reg_rdata <= {18'h00000, accel_time_zero_r};
            `REG_ACC1: reg_rdata <= {18'h00000, accel_time_one_r};
            `REG_DEC0: reg_rdata <= {18'h00000, decel_time_zero_r};
            `REG_DEC1: reg_rdata <= {18'h00000, decel_time_one_r};
            `REG_SELTIME: reg_rdata <= {12'h000, select_signal_on_time_r};
            `REG_RUN: reg_rdata <= {30'h00000000, cont_enable_r, 1'b0};
            `REG_PRESENT: reg_rdata <= {{(32-IW){1'b0}}, present_point};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// ---- test/motion_partner.sv ----
// Behavioural motion controller that answers each move with a done pulse.
`timescale 1ns/1ps
`default_nettype none
module motion_partner (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // Move handshake; lat sets how many cycles a move takes.
   input wire logic move_start,
   input wire logic [7:0] lat,
   output logic move_done
);
   logic [7:0] cnt_r;
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= 8'h00;
         move_done <= 1'b0;
      end else begin
         move_done <= (cnt_r == 8'h01);
         if (move_start)
            cnt_r <= lat;
         else if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
      end
   end
endmodule
`default_nettype wire

// ---- test/point_table_sequencer_properties.sv ----
// Port-level assertions for the point table sequencer.
`timescale 1ns/1ps
`default_nettype none
module point_table_sequencer_properties (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // Register port.
   input wire logic [3:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Motion side.
   input wire logic move_done,
   input wire logic move_start,
   input wire logic [31:0] target_pos,
   input wire logic [7:0] target_speed,
   input wire logic [13:0] target_accel,
   input wire logic [13:0] target_decel,
   input wire logic servo_lock
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside the read slot");
   a_start_single_pulse: assert property (move_start |=> !move_start)
      else $error("move start longer than one cycle");
   a_lock_after_done: assert property ($rose(servo_lock) |-> $past(move_done))
      else $error("servo lock without a finished move");
   a_unlock_on_start: assert property (move_start |=> !servo_lock)
      else $error("servo lock held while moving");
   // Offset by the limit so the signed window becomes one unsigned compare.
   a_target_pos_range: assert property ($past(move_start) |->
      (target_pos + 32'h026259ff) <= 32'h04c4b3fe) else $error("target out of range");
   a_target_speed_range: assert property ($past(move_start) |-> target_speed <= 8'hc7)
      else $error("target speed above limit");
   a_ramp_time_range: assert property ($past(move_start) |->
      target_accel <= 14'h270f && target_decel <= 14'h270f) else $error("ramp too long");
   a_sel_time_step: assert property ($past(reg_rd) && $past(reg_addr) == 4'ha |->
      reg_rdata % 32'h320 == 32'h0 && reg_rdata <= 32'hc3500)
      else $error("selection time not a step multiple");
   a_fields_in_range: assert property ($past(reg_rd) && $past(reg_addr) == 4'h3 |->
      reg_rdata[15:8] <= 8'hc7 && reg_rdata[25:24] <= 2'h2)
      else $error("stored fields out of range");
endmodule
bind point_table_sequencer point_table_sequencer_properties chk_inst (.core_clk(core_clk),
   .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .move_done(move_done), .move_start(move_start), .target_pos(target_pos),
   .target_speed(target_speed), .target_accel(target_accel), .target_decel(target_decel),
   .servo_lock(servo_lock));
`default_nettype wire

// ---- test/tb_point_table_sequencer.sv ----
// Self-checking bench for the point table sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_point_table_sequencer;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] lat = 8'h02;
   wire [31:0] reg_rdata, target_pos;
   wire [13:0] target_accel, target_decel;
   wire [7:0] target_speed;
   wire [5:0] present_point;
   wire move_done, move_start, target_incr, servo_lock;
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   logic rd_pend = 1'b0;
   logic mv_pend = 1'b0;
   logic [31:0] rd_q[$];
   logic [74:0] mv_q[$];
   logic [63:0] bad [4] = '{64'h02625a00_00000000, 64'hfd9da600_00000000, 64'hc800, 64'h03000000};
   logic [1:0] md [4] = '{2'h1, 2'h2, 2'h2, 2'h0};
   initial forever #25 core_clk = ~core_clk;
   point_table_sequencer point_table_sequencer_inst (.core_clk(core_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .move_done(move_done), .move_start(move_start),
      .target_pos(target_pos), .target_incr(target_incr), .target_speed(target_speed),
      .target_accel(target_accel), .target_decel(target_decel), .servo_lock(servo_lock),
      .present_point(present_point));
   motion_partner motion_partner_inst (.core_clk(core_clk), .sys_rst(sys_rst),
      .move_start(move_start), .lat(lat), .move_done(move_done));
   task automatic summarize;
      $display("Checks %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk_rd(logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] reg_rdata expected %h seen %h", e, g);
      end
   endtask
   task automatic chk_mv(logic [74:0] e, logic [74:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] point and target expected %h seen %h", e, g);
      end
   endtask
   task automatic chk_lock(logic e, logic g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] servo_lock expected %b seen %b", e, g);
      end
   endtask
   // Strobes stay high between back-to-back tasks, so each edge sees one assignment.
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, logic [31:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      rd_q.push_back(e);
   endtask
   task automatic idle(int n);
      repeat (n) begin
         @(posedge core_clk);
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
      end
   endtask
   task automatic put(logic [5:0] idx, logic [31:0] pos, logic [31:0] fld);
      wr(4'h1, {26'h0, idx});
      wr(4'h2, pos);
      wr(4'h3, fld);
      wr(4'h4, 32'h1);
   endtask
   task automatic rdi(logic [5:0] idx, logic [31:0] e);
      wr(4'h1, {26'h0, idx});
      rd(4'h2, e);
   endtask
   task automatic go(logic [31:0] run, int first, int n);
      for (int k = first; k < first + n; k++)
         mv_q.push_back({k[5:0], 32'(32'h100 + k), k[0], k[7:0],
            (k[0] ? 14'h270e : 14'h270f), (k[1] ? 14'h270c : 14'h270d)});
      lat <= 8'h02 + 8'($urandom % 40);
      wr(4'hb, run);
      idle(4);
      repeat (300) begin
         @(negedge core_clk);
         if (servo_lock === 1'b1 && mv_q.size() == 0)
            break;
      end
      chk_lock(1'b1, servo_lock === 1'b1 && mv_q.size() == 0);
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (rd_pend)
         chk_rd(rd_q.pop_front(), reg_rdata);
      if (mv_pend)
         chk_mv(mv_q.pop_front(), {present_point, target_pos, target_incr, target_speed,
            target_accel, target_decel});
      rd_pend <= reg_rd;
      mv_pend <= move_start;
      if (cyc == 20000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      int i;
      logic [31:0] p;
      void'($urandom(32'hbb87));
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(4'h2, 32'h0);
      rd(4'h3, 32'h0);
      rd(4'hd, 32'h0);
      $display("Test reset values done");
      put(6'h0, 32'h4d2, 32'h0);
      rd(4'h2, 32'h0);
      rd(4'h5, 32'h8);
      wr(4'h0, 32'hc);
      wr(4'h2, 32'h4d2);
      rd(4'h2, 32'h0);
      wr(4'h4, 32'h1);
      rd(4'h2, 32'h4d2);
      wr(4'h0, 32'hb);
      for (i = 0; i < 4; i++) begin
         p = $urandom % 32'h02625a00;
         put(6'h1, p, 32'h0);
         put(6'h1, bad[i][63:32], bad[i][31:0]);
         rd(4'h2, p);
         rd(4'h3, 32'h0);
         rd(4'h5, 32'hc);
      end
      put(6'h1, 32'hfd9da601, 32'h0211c701);
      rd(4'h2, 32'hfd9da601);
      rd(4'h3, 32'h0211c701);
      $display("Test edit and range done");
      put(6'h2, 32'h309, 32'h0);
      wr(4'h2, 32'h555);
      wr(4'h4, 32'h2);
      rd(4'h5, 32'hc);
      rdi(6'h3, 32'h0);
      put(6'h3f, 32'h3f, 32'h0);
      wr(4'h1, 32'h2);
      wr(4'h2, 32'h555);
      wr(4'h4, 32'h2);
      rdi(6'h2, 32'h555);
      rdi(6'h3, 32'h309);
      rdi(6'h1, 32'hfd9da601);
      rdi(6'h3f, 32'h0);
      put(6'h3f, 32'h3f, 32'h0);
      wr(4'h1, 32'h2);
      wr(4'h4, 32'h3);
      rdi(6'h2, 32'h309);
      rdi(6'h3e, 32'h3f);
      rdi(6'h3f, 32'h0);
      $display("Test insert and delete done");
      for (i = 0; i < 4; i++) begin
         wr(4'h6 + i[3:0], 32'h270f - i);
         wr(4'h6 + i[3:0], 32'h2710);
         rd(4'h6 + i[3:0], 32'h270f - i);
      end
      wr(4'ha, 32'h6a4);
      rd(4'ha, 32'h640);
      wr(4'ha, 32'hc3501);
      rd(4'ha, 32'h640);
      wr(4'ha, 32'hc3500);
      rd(4'ha, 32'hc3500);
      $display("Test parameters done");
      for (i = 10; i < 14; i++) put(i[5:0], 32'h100 + i,
         {6'h0, md[i - 10], 3'h0, i[1], 3'h0, i[0], i[7:0], 7'h0, i[0]});
      wr(4'h1, 32'ha);
      go(32'h3, 10, 1);
      go(32'h3, 11, 3);
      go(32'h3, 13, 1);
      wr(4'h1, 32'hb);
      go(32'h1, 11, 1);
      rd(4'hc, 32'hb);
      idle(4);
      $display("Test sequencing done");
      summarize();
   end
endmodule
`default_nettype wire
